// file: src/sbm_pkg.sv
// Purpose: Shared constants and types for the sideband switch select control
// Assumes: 125 MHz system clock
// Notes: Switch enable vector layout is fixed here for both modules
package sbm_pkg;
    // Clock period in picoseconds
    localparam int CLK_PERIOD_PS = 8000;
    // Debounce least time, ns (rounded up)
    localparam int DEBOUNCE_NS = 140;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Shutdown longest time, ns (rounded down)
    localparam int SHUTDOWN_NS = 200;
    localparam int SHUTDOWN_CYC = (SHUTDOWN_NS * 1000) / CLK_PERIOD_PS;
    // Power-good longest time, us (rounded down)
    localparam int PGOOD_US = 250;
    localparam int PGOOD_CYC = (PGOOD_US * 1000000) / CLK_PERIOD_PS;
    // Break-before-make gap in cycles
    localparam int BBM_CYC = 2;
    // Switch enable vector bit positions
    localparam int SW_W = 8;
    localparam int SW_B_DIRECT = 0;
    localparam int SW_B_CROSS = 1;
    localparam int SW_AUDIO = 2;
    localparam int SW_C_DIRECT = 3;
    localparam int SW_A_DIRECT = 4;
    localparam int SW_A_CROSS = 5;
    // Path choice codes
    localparam logic [1:0] PATH_LANE_B = 2'h0;
    localparam logic [1:0] PATH_AUDIO = 2'h1;
    localparam logic [1:0] PATH_LANE_C = 2'h2;
    localparam logic [1:0] PATH_LANE_A = 2'h3;
    // Strap level encoding
    typedef enum logic [1:0] {
        STRAP_LOW = 2'b00,
        STRAP_MID = 2'b01,
        STRAP_HIGH = 2'b10
    } sbm_strap_t;
    // Reset value of the switch vector
    localparam logic [SW_W-1:0] SW_ALL_OFF = 8'h00;
endpackage : sbm_pkg

// file: src/sbm_sel_if.sv
// Purpose: Carries the wanted switch vector to the sequencer
// Assumes: Same clock on both sides
// Notes: Request is a level, not a pulse
interface sbm_sel_if;
    import sbm_pkg::*;
    logic [SW_W-1:0] want; // Wanted switch set
    logic off_now; // Force all paths open
    logic [SW_W-1:0] sw; // Switches actually closed
    modport src (output want, output off_now, input sw);
    modport seq (input want, input off_now, output sw);
endinterface : sbm_sel_if

// file: src/sbm_bbm_seq.sv
// Purpose: Break-before-make sequencer for the switch vector
// Assumes: Wanted vector is already debounced
// Notes: Opens all, waits, then closes the new set
module sbm_bbm_seq
    import sbm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    sbm_sel_if.seq sel
);
    logic [SW_W-1:0] sw_reg, sw_next; // Closed switches
    logic [3:0] gap_reg, gap_next; // Open-gap counter
    // Next-state computation
    always_comb begin
        sw_next = sw_reg;
        gap_next = gap_reg;
        if (sel.off_now) begin
            // Shutdown wins immediately
            sw_next = SW_ALL_OFF;
            gap_next = 4'(BBM_CYC);
        end else if (sel.want != sw_reg) begin
            if (sw_reg != SW_ALL_OFF) begin
                // Break first, never overlap two paths
                sw_next = SW_ALL_OFF;
                gap_next = 4'(BBM_CYC);
            end else if (gap_reg != 4'h0) begin
                gap_next = gap_reg - 4'h1;
            end else begin
                sw_next = sel.want;
            end
        end
    end
    // Registers
    always_ff @(posedge clk) begin
        if (srst) begin
            sw_reg <= SW_ALL_OFF;
            gap_reg <= 4'h0;
        end else begin
            sw_reg <= sw_next;
            gap_reg <= gap_next;
        end
    end
    assign sel.sw = sw_reg;
endmodule : sbm_bbm_seq

// file: src/sbm_select_ctrl.sv
// Purpose: Mode decode and switch select control of the sideband mux
// Assumes: Pins asynchronous; register fields come from same-clock logic
// Notes: I2C engine lies outside; this block exposes its enable and address pick
// Notes: Strap is retaken only after an enable-pin off and on cycle or a synchronous reset
// How it works
// - Three-level strap selects pin or register mode
// - Strap enables target and picks its address
// - Register code 00x B,01x audio,10x C,11x A
// - Pin code LL B,LH audio,HL C,HH A
// - Swap only available in register mode
// - Swap never exchanges audio pair pins
// - Lane B and A polarity reversible by active swap control, lane C never crossed
// - Open old switches before closing new
// - Debounce select pins and strap 140 ns; enable pin is not debounced
// - Shut all paths within 200 ns
// - Power-good within 250 us, sample after
// - Three lane paths plus one audio path
// - Unselected ports stay high impedance
// - Enable pin gates operation; device-on bit gates it in register mode only
module sbm_select_ctrl
    import sbm_pkg::*;
#(
    parameter int PGOOD_COUNT = PGOOD_CYC,
    parameter int DB_COUNT = DEBOUNCE_CYC
) (
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic STRAP_MID_IN,
    input wire logic STRAP_HIGH_IN,
    input wire logic PATH_PICK_PIN_LO,
    input wire logic PATH_PICK_PIN_HI,
    input wire logic [1:0] PATH_CHOICE_FIELD,
    input wire logic POLARITY_SWAP_FIELD,
    input wire logic DEVICE_ON,
    output logic POWER_GOOD,
    output logic TARGET_ENABLE,
    output logic TARGET_ADDR_SECOND,
    output logic REG_MODE,
    output logic [SW_W-1:0] SWITCH_EN
);
    // Raw pins, packed for a shared synchroniser
    localparam int NP = 5;
    // Packed order: strap high, strap mid, pick hi, pick lo, enable_n
    logic [NP-1:0] raw;
    logic [NP-1:0] s1_reg, s2_reg; // Two-flop synchroniser
    // Debounce state
    logic [NP-1:0] stab_reg, stab_next; // Debounced levels
    logic [NP-1:0] last_reg, last_next; // Previous synced value
    logic [7:0] db_reg, db_next; // Stability counter
    // Power-good and strap state
    logic [19:0] pg_reg, pg_next; // Power-good counter
    logic pwr_ok_reg, pwr_ok_next; // Power-good flag
    sbm_strap_t strap_reg, strap_next; // Latched mode strap
    logic en_reg, en_next; // Target interface on
    logic addr_reg, addr_next; // Second target address
    // Route decode
    logic [SW_W-1:0] want; // Decoded switch set
    logic [1:0] code; // Active path code
    logic swap; // Active swap bit
    logic run; // Switches may close
    // Carrier to the sequencer
    sbm_sel_if sel_if ();

    assign raw = {STRAP_HIGH_IN, STRAP_MID_IN, PATH_PICK_PIN_HI, PATH_PICK_PIN_LO,
                  OUTPUT_ENABLE_N};

    // Synchroniser, first stage read only by the second
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            // Idle value matches a disabled device, so no false enable edge
            s1_reg <= 5'h01;
            s2_reg <= 5'h01;
        end else begin
            // Pins sampled every edge
            s1_reg <= raw;
            s2_reg <= s1_reg;
        end
    end

    // Debounce group: a new level counts only after it has held for the window.
    // The enable pin skips the window, since waiting on it would overrun shutdown.
    always_comb begin
        last_next = s2_reg;
        stab_next = stab_reg;
        db_next = db_reg;
        if (s2_reg != last_reg) begin
            // Any change restarts the stability window
            db_next = 8'h00;
        end else if (db_reg < 8'(DB_COUNT)) begin
            // Still settling
            db_next = db_reg + 8'h01;
        end else begin
            // Held long enough, take the new level
            stab_next = s2_reg;
        end
        // Enable pin is the fast path
        stab_next[0] = s2_reg[0];
    end

    // Registers for the debounce group; idle levels match a disabled device
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            last_reg <= 5'h01;
            stab_reg <= 5'h01;
            db_reg <= 8'h00;
        end else begin
            last_reg <= last_next;
            stab_reg <= stab_next;
            db_reg <= db_next;
        end
    end

    // Power-good group: count from enable low, then take the strap once.
    // A strap moved while running is ignored until the next enable cycle or SRST.
    always_comb begin
        pg_next = pg_reg;
        pwr_ok_next = pwr_ok_reg;
        strap_next = strap_reg;
        en_next = en_reg;
        addr_next = addr_reg;
        if (s2_reg[0]) begin
            // Held in reset: target off, power-good dropped
            pg_next = 20'h0;
            pwr_ok_next = 1'b0;
            en_next = 1'b0;
        end else if (!pwr_ok_reg) begin
            if (pg_reg < 20'(PGOOD_COUNT)) begin
                // Supply still settling, pins not yet trusted
                pg_next = pg_reg + 20'h1;
            end else begin
                pwr_ok_next = 1'b1;
                // Strap sampled once, after power-good
                if (stab_reg[4]) begin
                    strap_next = STRAP_HIGH;
                end else if (stab_reg[3]) begin
                    strap_next = STRAP_MID;
                end else begin
                    // Low or floating strap
                    strap_next = STRAP_LOW;
                end
                en_next = stab_reg[4] | stab_reg[3];
                addr_next = stab_reg[4];
            end
        end
    end

    // Registers for the power-good group
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            pg_reg <= 20'h0;
            pwr_ok_reg <= 1'b0;
            strap_reg <= STRAP_LOW;
            en_reg <= 1'b0;
            addr_reg <= 1'b0;
        end else begin
            pg_reg <= pg_next;
            pwr_ok_reg <= pwr_ok_next;
            strap_reg <= strap_next;
            en_reg <= en_next;
            addr_reg <= addr_next;
        end
    end

    // Route decode from the active configuration source
    always_comb begin
        if (strap_reg == STRAP_LOW) begin
            // Pin mode: select pins, never swapped
            code = {stab_reg[2], stab_reg[1]};
            swap = 1'b0;
        end else begin
            // Register mode: stored code and swap bit, pins ignored
            code = PATH_CHOICE_FIELD;
            swap = POLARITY_SWAP_FIELD;
        end
        // Device-on bit only counts in register mode
        run = pwr_ok_reg && !stab_reg[0] && (strap_reg == STRAP_LOW || DEVICE_ON);
        // Start from all open; unselected ports float
        want = SW_ALL_OFF;
        unique case (code)
            // Swap picks the crossed switch of a lane pair
            PATH_LANE_B: want[swap ? SW_B_CROSS : SW_B_DIRECT] = 1'b1;
            // Audio pair keeps its order whatever the swap
            PATH_AUDIO: want[SW_AUDIO] = 1'b1;
            PATH_LANE_C: want[SW_C_DIRECT] = 1'b1;
            PATH_LANE_A: want[swap ? SW_A_CROSS : SW_A_DIRECT] = 1'b1;
        endcase
        if (!run) begin
            // Shutdown overrides any selection
            want = SW_ALL_OFF;
        end
    end

    // Sequencer request and shutdown, both levels
    assign sel_if.want = want;
    assign sel_if.off_now = !run;

    // Break-before-make sequencer
    // It opens at once on shutdown but waits out the gap before closing
    sbm_bbm_seq u_seq (
        .clk(CLOCK),
        .srst(SRST),
        .sel(sel_if)
    );

    // Output registers, so every port comes straight from a flip-flop
    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            // All outputs low through reset
            POWER_GOOD <= 1'b0;
            TARGET_ENABLE <= 1'b0;
            TARGET_ADDR_SECOND <= 1'b0;
            REG_MODE <= 1'b0;
            SWITCH_EN <= SW_ALL_OFF;
        end else begin
            POWER_GOOD <= pwr_ok_reg;
            TARGET_ENABLE <= en_reg;
            TARGET_ADDR_SECOND <= addr_reg;
            // Mode flag follows the latched strap
            REG_MODE <= (strap_reg != STRAP_LOW);
            // One cycle behind the sequencer
            SWITCH_EN <= sel_if.sw;
        end
    end
endmodule : sbm_select_ctrl

// file: test/sbm_ctrl_sva.sv
// Purpose: Port assertions for the sideband switch select control
// Assumes: Bound to the top module, one clock domain
// Notes: Delays counted in CLOCK cycles
module sbm_ctrl_sva
    import sbm_pkg::*;
(
    input wire logic CLOCK,
    input wire logic SRST,
    input wire logic OUTPUT_ENABLE_N,
    input wire logic DEVICE_ON,
    input wire logic POWER_GOOD,
    input wire logic TARGET_ENABLE,
    input wire logic TARGET_ADDR_SECOND,
    input wire logic REG_MODE,
    input wire logic [SW_W-1:0] SWITCH_EN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (SRST);
    // Never two paths at once, the rest float
    AST_ONE_PATH: assert property ($onehot0(SWITCH_EN))
        else $error("more than one path closed");
    // A new set only closes after a fully open cycle
    AST_BREAK_FIRST: assert property (($past(SWITCH_EN) != 8'h00 && SWITCH_EN != 8'h00)
        |-> SWITCH_EN == $past(SWITCH_EN)) else $error("path changed without break");
    // Shutdown within 25 cycles of 8 ns
    AST_SHUTDOWN: assert property ($rose(OUTPUT_ENABLE_N) |-> ##[1:25] SWITCH_EN == 8'h00)
        else $error("paths still closed after disable");
    // Only four paths exist
    AST_SPARE_BITS: assert property (SWITCH_EN[7:6] == 2'h0)
        else $error("spare switch bits set");
    // Target only on in register mode
    AST_TARGET_MODE: assert property (TARGET_ENABLE |-> REG_MODE)
        else $error("target on in pin mode");
    // Second address only in register mode
    AST_ADDR_MODE: assert property (TARGET_ADDR_SECOND |-> REG_MODE)
        else $error("second address in pin mode");
    // Nothing closes before power-good
    AST_PGOOD_FIRST: assert property ($rose(POWER_GOOD) |-> $past(SWITCH_EN) == 8'h00)
        else $error("switch closed before power good");
    // Device-on bit cleared in register mode opens everything
    AST_DEVICE_OFF: assert property ((REG_MODE && !DEVICE_ON) [*8] |-> SWITCH_EN == 8'h00)
        else $error("paths closed with device off");
    // Pin mode has no crossed lanes
    AST_PIN_NO_SWAP: assert property ((!REG_MODE && POWER_GOOD && !OUTPUT_ENABLE_N)
        |-> !SWITCH_EN[SW_B_CROSS] && !SWITCH_EN[SW_A_CROSS]) else $error("swap in pin mode");
    // Main scenarios reached
    cover property ($rose(SWITCH_EN[SW_AUDIO]));
    cover property ($rose(SWITCH_EN[SW_A_CROSS]));
    cover property ($rose(TARGET_ADDR_SECOND));
endmodule : sbm_ctrl_sva

// file: test/sbm_host_model.sv
// Purpose: Port controller model driving strap, select pins and fields
// Assumes: Bench requests levels; model applies them on the falling edge
// Notes: Levels stand until the next request
module sbm_host_model
    import sbm_pkg::*;
(
    input wire logic clk,
    input wire logic [8:0] want, // {oe_n, on, strap, pins hi/lo, code}
    output logic [8:0] drive, // Levels as seen on the pins
    output logic strap_mid, // Strap at mid level
    output logic strap_high // Strap at full level
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] req_reg; // Request taken on the rising edge
    // Take the request away from the falling edge the bench writes on
    always_ff @(posedge clk) begin
        req_reg <= want;
    end
    // Change only off the sampling edge, then hold steady
    always_ff @(negedge clk) begin
        drive <= req_reg;
    end
    // Three strap levels onto two digital pins
    assign strap_mid = drive[6:5] == STRAP_MID;
    assign strap_high = drive[6:5] == STRAP_HIGH;
endmodule : sbm_host_model

// file: test/tb_top.sv
// Purpose: Self-checking bench for the sideband switch select control
// Assumes: Short power-good count in simulation
// Notes: Table of routings, then glitch and device-off cases
module tb_top
    import sbm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] strap; // Strap level
        logic [4:0] sel; // {pins, code}
        logic [7:0] sw; // Expected switch set
        logic [2:0] mode; // Expected {reg, target, second}
    } sbm_row_t;
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [8:0] want = 9'h080; // Enabled, device on, pin mode
    logic [8:0] drive;
    logic s_mid, s_high, pg, ten, tas, rm;
    logic [7:0] sw;
    logic [1:0] cur = 2'h3; // Current strap, none yet
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    // Pin rows carry a contrary code, register rows contrary pins except the lane A rows
    sbm_row_t rows [12] = '{
        '{2'h0, 5'h07, 8'h01, 3'h0}, '{2'h0, 5'h08, 8'h04, 3'h0},
        '{2'h0, 5'h10, 8'h08, 3'h0}, '{2'h0, 5'h19, 8'h10, 3'h0},
        '{2'h1, 5'h18, 8'h01, 3'h6}, '{2'h1, 5'h19, 8'h02, 3'h6},
        '{2'h1, 5'h1a, 8'h04, 3'h6}, '{2'h1, 5'h1b, 8'h04, 3'h6},
        '{2'h1, 5'h1c, 8'h08, 3'h6}, '{2'h1, 5'h1d, 8'h08, 3'h6},
        '{2'h2, 5'h1e, 8'h10, 3'h7}, '{2'h2, 5'h1f, 8'h20, 3'h7}};
    always #4 clock = ~clock;
    sbm_host_model u_sbm_host_model (.clk(clock), .want(want), .drive(drive),
        .strap_mid(s_mid), .strap_high(s_high));
    sbm_select_ctrl #(.PGOOD_COUNT(20), .DB_COUNT(DEBOUNCE_CYC)) u_sbm_select_ctrl (
        .CLOCK(clock), .SRST(srst), .OUTPUT_ENABLE_N(drive[8]), .STRAP_MID_IN(s_mid),
        .STRAP_HIGH_IN(s_high), .PATH_PICK_PIN_LO(drive[3]), .PATH_PICK_PIN_HI(drive[4]),
        .PATH_CHOICE_FIELD(drive[2:1]), .POLARITY_SWAP_FIELD(drive[0]), .DEVICE_ON(drive[7]),
        .POWER_GOOD(pg), .TARGET_ENABLE(ten), .TARGET_ADDR_SECOND(tas), .REG_MODE(rm),
        .SWITCH_EN(sw));
    // Compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // Disable, new strap while off, enable and wait for power-good
    task automatic power_cycle(input logic [1:0] s);
        int n;
        want[8] = 1'b1;
        repeat (26) @(negedge clock);
        check("shutdown", sw, 8'h00);
        want[6:5] = s;
        repeat (30) @(negedge clock);
        want[8] = 1'b0;
        n = 0;
        while (pg !== 1'b1 && n < 200) begin
            @(negedge clock);
            n++;
        end
        check("power_good", {7'h0, pg}, 8'h01);
    endtask : power_cycle
    // Hang guard, tests need about 950 cycles
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(negedge clock);
        srst = 1'b0;
        foreach (rows[i]) begin
            if (rows[i].strap != cur) power_cycle(rows[i].strap);
            cur = rows[i].strap;
            want[4:0] = rows[i].sel;
            repeat (40) @(negedge clock);
            check("switch", sw, rows[i].sw);
            check("mode", {5'h0, rm, ten, tas}, {5'h0, rows[i].mode});
        end
        want[7] = 1'b0;
        repeat (20) @(negedge clock);
        check("device_off", sw, 8'h00);
        want[7] = 1'b1;
        power_cycle(2'h0);
        want[4:0] = 5'h18;
        repeat (40) @(negedge clock);
        // Pulse on the pins shorter than the debounce window
        want[4:3] = 2'h0;
        repeat (14) @(negedge clock);
        check("glitch_mid", sw, 8'h10);
        repeat (1) @(negedge clock);
        want[4:3] = 2'h3;
        want[7] = 1'b0;
        repeat (12) @(negedge clock);
        check("glitch", sw, 8'h10);
        // Reset in mid-run: all opens, power-good restarts
        srst = 1'b1;
        repeat (2) @(negedge clock);
        check("reset_sw", sw, 8'h00);
        check("reset_flags", {4'h0, pg, rm, ten, tas}, 8'h00);
        srst = 1'b0;
        repeat (40) @(negedge clock);
        check("reset_pg", {7'h0, pg}, 8'h01);
        check("reset_sw_back", sw, 8'h10);
        test_done();
    end
endmodule : tb_top
bind sbm_select_ctrl sbm_ctrl_sva u_sbm_ctrl_sva (.CLOCK, .SRST, .OUTPUT_ENABLE_N, .DEVICE_ON,
    .POWER_GOOD, .TARGET_ENABLE, .TARGET_ADDR_SECOND, .REG_MODE, .SWITCH_EN);
